// *** design/subams_pin_sync.sv ***
// Purpose: Two-flop synchronisers for the three asynchronous init and standby pins
// Assumes: Pins are idle high; reset presets the flops high
// Notes: The first stage feeds only the second
`timescale 1ns/1ns
module subams_pin_sync
    import subams_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Raw pins
    input wire logic cold_init_pin_n,
    input wire logic manual_init_pin_n,
    input wire logic hw_standby_pin_n,
    // Synchronised levels
    subams_sync_if.src sync
);
    logic [2:0] meta_reg;
    logic [2:0] stable_reg;

    // Two-stage synchroniser chain
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_reg <= 3'h7;
            stable_reg <= 3'h7;
        end
        else
        begin
            meta_reg <= {hw_standby_pin_n, manual_init_pin_n, cold_init_pin_n};
            stable_reg <= meta_reg;
        end
    end

    // Hand levels over to the sequencer
    assign sync.cold_init_n = stable_reg[0];
    assign sync.manual_init_n = stable_reg[1];
    assign sync.hw_standby_n = stable_reg[2];
endmodule // subams_pin_sync

// *** design/subams_pkg.sv ***
// Purpose: Shared constants and types for the subactive mode sequencer
// Assumes: One 100 MHz clock, synchronous active-low reset
// Notes: Mode encodings follow a Gray path high-speed -> subactive -> watch -> subsleep
package subams_pkg;

    // Power modes, Gray coded along high-speed -> subactive -> watch -> subsleep
    typedef enum logic [2:0] {
        SUBAMS_HIGH_SPEED = 3'b000,
        SUBAMS_SUBACTIVE  = 3'b001,
        SUBAMS_WATCH      = 3'b011,
        SUBAMS_SUBSLEEP   = 3'b010,
        SUBAMS_HW_STANDBY = 3'b110,
        SUBAMS_RESET      = 3'b111
    } subams_mode_t;

    // Divider width and the value required for low-speed operation
    localparam int SUBAMS_DIV_W = 3;
    localparam logic [2:0] SUBAMS_DIV_ZERO = 3'h0;

    // Reset value of the mode
    localparam subams_mode_t SUBAMS_MODE_RST = SUBAMS_HIGH_SPEED;

    // Gate bit positions in the clock enable vector
    localparam int SUBAMS_GATE_W = 5;
    localparam int SUBAMS_GATE_SYSOSC = 0;
    localparam int SUBAMS_GATE_CPU_MAIN = 1;
    localparam int SUBAMS_GATE_CPU_SUB = 2;
    localparam int SUBAMS_GATE_KEPT = 3;
    localparam int SUBAMS_GATE_OTHER = 4;

endpackage

// *** design/subams_sequencer.sv ***
// Purpose: Power-mode sequencer for entry to and exit from subactive mode
// Assumes: Core issues a one-cycle sleep strobe; control bits are stable around it
// Notes: Reset pins return the chip via an init state, then to high-speed mode
`timescale 1ns/1ns

// Overview of operation
// R01 - Sleep in high-speed with standby, direct, low-speed, prescaler bits all 1 enters subactive.
// R02 - Interrupt in watch mode with low-speed-on 1 goes to subactive.
// R03 - Interrupt in subsleep always returns to subactive.
// R04 - Subactive: core on subclock, main oscillator and most peripherals stopped.
// R05 - Software zeros the clock divider before running in subactive.
// R06 - Sleep in subactive, standby 1, direct 0, prescaler 1 goes to watch.
// R07 - Sleep in subactive, standby 0, low-speed 1, prescaler 1 goes to subsleep.
// R08 - Sleep in subactive, standby 1, direct 1, low-speed 0, prescaler 1 goes high-speed.
// R09 - Subactive exits by sleep, cold init, manual init or hardware standby pin.
// R10 - Hardware standby pin low forces hardware standby on the third clock edge, after the two-flop synchroniser.
module subams_sequencer
    import subams_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins, active low, asynchronous
    input wire logic cold_init_pin_n,
    input wire logic manual_init_pin_n,
    input wire logic hw_standby_pin_n,
    // Core requests
    input wire logic sleep_req,
    input wire logic irq_req,
    // Control bits
    input wire logic standby_select_bit,
    input wire logic direct_transfer_bit,
    input wire logic low_speed_on_bit,
    input wire logic watchdog_prescaler_select,
    input wire logic [SUBAMS_DIV_W-1:0] system_clock_divider,
    // Status
    output subams_mode_t mode,
    output logic [SUBAMS_GATE_W-1:0] clock_gates,
    output logic divider_fault,
    output logic to_high_speed
);
    subams_sync_if sync_if ();
    subams_mode_t mode_reg;
    subams_mode_t mode_next;
    logic [SUBAMS_GATE_W-1:0] gates_reg;
    logic [SUBAMS_GATE_W-1:0] gates_next;
    logic fault_reg;
    logic hs_pulse_reg;

    subams_pin_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .cold_init_pin_n(cold_init_pin_n),
        .manual_init_pin_n(manual_init_pin_n),
        .hw_standby_pin_n(hw_standby_pin_n),
        .sync(sync_if.src)
    );

    // Decoded conditions
    wire init_active = !sync_if.cold_init_n || !sync_if.manual_init_n;
    wire standby_active = !sync_if.hw_standby_n;
    wire in_sub = (mode_reg == SUBAMS_SUBACTIVE);
    wire go_sub_from_hs = standby_select_bit && direct_transfer_bit && low_speed_on_bit
        && watchdog_prescaler_select; // R01
    wire go_watch = standby_select_bit && !direct_transfer_bit && watchdog_prescaler_select; // R06
    wire go_subsleep = !standby_select_bit && low_speed_on_bit && watchdog_prescaler_select; // R07
    wire go_hs = standby_select_bit && direct_transfer_bit && !low_speed_on_bit
        && watchdog_prescaler_select; // R08

    // Next-mode selection; standby pin outranks init pins, which outrank sleep
    always_comb
    begin
        mode_next = mode_reg;
        if (standby_active)
            mode_next = SUBAMS_HW_STANDBY; // R10
        else if (init_active)
            mode_next = SUBAMS_RESET; // R09
        else
            unique case (mode_reg)
                SUBAMS_HIGH_SPEED:
                begin
                    if (sleep_req && go_sub_from_hs)
                        mode_next = SUBAMS_SUBACTIVE; // R01
                end
                SUBAMS_SUBACTIVE:
                begin
                    if (sleep_req && go_watch)
                        mode_next = SUBAMS_WATCH; // R06 R09
                    else if (sleep_req && go_subsleep)
                        mode_next = SUBAMS_SUBSLEEP; // R07 R09
                    else if (sleep_req && go_hs)
                        mode_next = SUBAMS_HIGH_SPEED; // R08 R09
                end
                SUBAMS_WATCH:
                begin
                    if (irq_req && low_speed_on_bit)
                        mode_next = SUBAMS_SUBACTIVE; // R02
                end
                SUBAMS_SUBSLEEP:
                begin
                    if (irq_req)
                        mode_next = SUBAMS_SUBACTIVE; // R03
                end
                SUBAMS_HW_STANDBY:
                    mode_next = SUBAMS_RESET;
                SUBAMS_RESET:
                    mode_next = SUBAMS_HIGH_SPEED;
                default:
                    mode_next = SUBAMS_MODE_RST;
            endcase
    end

    // Clock gating per mode: subactive keeps subclock core and the kept peripherals only
    always_comb
    begin
        gates_next = '0;
        unique case (mode_next)
            SUBAMS_HIGH_SPEED:
                gates_next = 5'h1B;
            SUBAMS_SUBACTIVE:
            begin
                gates_next[SUBAMS_GATE_CPU_SUB] = 1'b1; // R04
                gates_next[SUBAMS_GATE_KEPT] = 1'b1; // R04
            end
            SUBAMS_WATCH:
                gates_next[SUBAMS_GATE_KEPT] = 1'b1;
            SUBAMS_SUBSLEEP:
                gates_next[SUBAMS_GATE_KEPT] = 1'b1;
            SUBAMS_RESET:
                gates_next[SUBAMS_GATE_SYSOSC] = 1'b1;
            default:
                gates_next = '0;
        endcase
    end

    // State, gates and status flags
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mode_reg <= SUBAMS_MODE_RST;
            gates_reg <= 5'h1B;
            fault_reg <= 1'b0;
            hs_pulse_reg <= 1'b0;
        end
        else
        begin
            mode_reg <= mode_next;
            gates_reg <= gates_next;
            fault_reg <= in_sub && (system_clock_divider != SUBAMS_DIV_ZERO); // R05
            hs_pulse_reg <= in_sub && (mode_next == SUBAMS_HIGH_SPEED); // R08
        end
    end

    assign mode = mode_reg;
    assign clock_gates = gates_reg;
    assign divider_fault = fault_reg;
    assign to_high_speed = hs_pulse_reg;
endmodule // subams_sequencer

// *** design/subams_sync_if.sv ***
// Purpose: Carries synchronised pin levels from the synchroniser to the sequencer
// Assumes: Same clock domain on both sides
// Notes: Levels only, active low as on the pins
`timescale 1ns/1ns
interface subams_sync_if;
    logic cold_init_n;
    logic manual_init_n;
    logic hw_standby_n;
    modport src (output cold_init_n, output manual_init_n, output hw_standby_n);
    modport dst (input cold_init_n, input manual_init_n, input hw_standby_n);
endinterface

// *** testbench/subams_core_model.sv ***
// Purpose: Core model issuing sleep and interrupt strobes
// Assumes: Requests change at the falling edge, one-cycle strobes
// Notes: Divider starts at zero, as software must before subactive use; set_div can change it
`timescale 1ns/1ns
module subams_core_model
(
    // Clock
    input wire logic clk,
    // Requests and control bits
    output logic sleep_req,
    output logic irq_req,
    output logic standby_select_bit,
    output logic direct_transfer_bit,
    output logic low_speed_on_bit,
    output logic watchdog_prescaler_select,
    output logic [2:0] system_clock_divider
);
    // Divider cleared before the core runs on the subclock
    initial system_clock_divider = 3'h0;
    initial {sleep_req, irq_req, standby_select_bit, direct_transfer_bit} = 4'h0;
    initial {low_speed_on_bit, watchdog_prescaler_select} = 2'h0;
    // One strobe with its control bits held across the sampling edge
    task automatic req(input logic is_irq, input logic [3:0] b);
        @(negedge clk);
        {standby_select_bit, direct_transfer_bit, low_speed_on_bit, watchdog_prescaler_select} = b;
        {irq_req, sleep_req} = {is_irq, !is_irq};
        @(negedge clk);
        {irq_req, sleep_req} = 2'h0;
    endtask
    // Divider value for one deliberate misuse and its repair
    task automatic set_div(input logic [2:0] v);
        @(negedge clk);
        system_clock_divider = v;
        @(negedge clk);
    endtask
endmodule // subams_core_model

// *** testbench/subams_sequencer_props.sv ***
// Purpose: Mode transition properties at the sequencer ports
// Assumes: Requests only count while all pins are idle
// Notes: Bound to every sequencer instance
`timescale 1ns/1ns
module subams_sequencer_props
    import subams_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins and requests
    input wire logic cold_init_pin_n,
    input wire logic manual_init_pin_n,
    input wire logic hw_standby_pin_n,
    input wire logic sleep_req,
    input wire logic irq_req,
    // Control bits
    input wire logic standby_select_bit,
    input wire logic direct_transfer_bit,
    input wire logic low_speed_on_bit,
    input wire logic watchdog_prescaler_select,
    input wire logic [SUBAMS_DIV_W-1:0] system_clock_divider,
    // Status
    input wire subams_mode_t mode,
    input wire logic [SUBAMS_GATE_W-1:0] clock_gates,
    input wire logic divider_fault,
    input wire logic to_high_speed
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Pins idle and packed control bits
    wire quiet = cold_init_pin_n & manual_init_pin_n & hw_standby_pin_n;
    logic [1:0] quiet_hist;
    // Pins idle for the last two edges too, so the synchronised levels are idle as well
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            quiet_hist <= 2'b11;
        else
            quiet_hist <= {quiet_hist[0], quiet};
    end
    wire settled = quiet && (&quiet_hist);
    wire [3:0] c = {standby_select_bit, direct_transfer_bit, low_speed_on_bit, watchdog_prescaler_select};
    wire sub_sl = settled && sleep_req && mode == SUBAMS_SUBACTIVE;
    a_enter_sub: assert property (settled && sleep_req && mode == SUBAMS_HIGH_SPEED && c == 4'hF
        |=> mode == SUBAMS_SUBACTIVE) else $error("no subactive entry");
    a_watch_wake: assert property (settled && irq_req && low_speed_on_bit && mode == SUBAMS_WATCH
        |=> mode == SUBAMS_SUBACTIVE) else $error("no watch wake");
    a_subsleep_wake: assert property (settled && irq_req && mode == SUBAMS_SUBSLEEP
        |=> mode == SUBAMS_SUBACTIVE) else $error("no subsleep wake");
    a_divider_flag: assert property (mode == SUBAMS_SUBACTIVE && system_clock_divider != SUBAMS_DIV_ZERO
        |=> divider_fault) else $error("divider fault missed");
    a_divider_quiet: assert property (mode != SUBAMS_SUBACTIVE |=> !divider_fault)
        else $error("divider fault outside subactive");
    a_sub_gates: assert property (mode == SUBAMS_SUBACTIVE |-> clock_gates == 5'h0C)
        else $error("subactive gates wrong");
    a_to_watch: assert property (sub_sl && c[3] && !c[2] && c[0] |=> mode == SUBAMS_WATCH)
        else $error("no watch entry");
    a_to_subsleep: assert property (sub_sl && !c[3] && c[1] && c[0] |=> mode == SUBAMS_SUBSLEEP)
        else $error("no subsleep entry");
    a_to_high: assert property (sub_sl && c == 4'hD |=> mode == SUBAMS_HIGH_SPEED && to_high_speed)
        else $error("no high-speed exit");
    a_standby_pin: assert property ($fell(hw_standby_pin_n) |-> ##3 mode == SUBAMS_HW_STANDBY)
        else $error("no hw standby");
endmodule // subams_sequencer_props
bind subams_sequencer subams_sequencer_props u_props (.*);

// *** testbench/subams_sequencer_tb.sv ***
// Purpose: Walks the sequencer through every subactive entry and exit
// Assumes: Inputs change at the falling edge
// Notes: Pin exits checked after synchroniser latency
`timescale 1ns/1ns
module subams_sequencer_tb;
    import subams_pkg::*;
    logic clk = 0, rst_n = 0, cold_init_pin_n = 1, manual_init_pin_n = 1, hw_standby_pin_n = 1;
    logic sleep_req, irq_req, standby_select_bit, direct_transfer_bit, low_speed_on_bit;
    logic watchdog_prescaler_select, divider_fault, to_high_speed;
    logic [2:0] system_clock_divider;
    logic [4:0] clock_gates;
    subams_mode_t mode;
    int fails = 0, tests_run = 0;
    subams_sequencer DUT (.*);
    subams_core_model u_core (.*);
    initial forever #5 clk = ~clk;
    // Compare and count
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // Enter subactive, pull a pin, release it
    task automatic pin_exit(input logic [2:0] p, input logic [2:0] exp);
        u_core.req(0, 4'hF);
        {hw_standby_pin_n, manual_init_pin_n, cold_init_pin_n} = ~p;
        repeat (3) @(negedge clk);
        chk("pin mode", mode, exp);
        {hw_standby_pin_n, manual_init_pin_n, cold_init_pin_n} = 3'h7;
        repeat (5) @(negedge clk);
        chk("after pin", mode, SUBAMS_HIGH_SPEED);
    endtask
    task automatic finish_test;
        if (fails == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #20000;
        fails++;
        finish_test;
    end
    initial
    begin
        repeat (3) @(negedge clk);
        rst_n = 1;
        chk("gates rst", clock_gates, 5'h1B);
        u_core.req(0, 4'hF);
        chk("enter", mode, SUBAMS_SUBACTIVE);
        chk("gates", clock_gates, 5'h0C);
        chk("no pulse", to_high_speed, 1'h0);
        u_core.set_div(3'h5);
        chk("div fault", divider_fault, 1'h1);
        u_core.set_div(3'h0);
        chk("div clear", divider_fault, 1'h0);
        u_core.req(0, 4'h6);
        chk("no prescaler", mode, SUBAMS_SUBACTIVE);
        u_core.req(0, 4'hB);
        chk("watch", mode, SUBAMS_WATCH);
        u_core.req(1, 4'h2);
        chk("watch wake", mode, SUBAMS_SUBACTIVE);
        u_core.req(0, 4'h3);
        chk("subsleep", mode, SUBAMS_SUBSLEEP);
        u_core.req(1, 4'h0);
        chk("sleep wake", mode, SUBAMS_SUBACTIVE);
        u_core.req(0, 4'hD);
        chk("high", mode, SUBAMS_HIGH_SPEED);
        chk("high pulse", to_high_speed, 1'h1);
        pin_exit(3'h4, SUBAMS_HW_STANDBY);
        pin_exit(3'h2, SUBAMS_RESET);
        pin_exit(3'h1, SUBAMS_RESET);
        finish_test;
    end
endmodule // subams_sequencer_tb
